// ### bip_pkg.sv
// package: constants and types for the baseband input port
`default_nettype none
package bip_pkg;
    // =====================================================
    // operating modes (control_function_reg_one mode field)
    typedef enum logic [1:0] {
        BIP_MODE_QUAD   = 2'h0,
        BIP_MODE_INTERP = 2'h1,
        BIP_MODE_TONE   = 2'h2
    } bip_mode_t;
    // =====================================================
    // widths
    localparam int BIP_PAR_W   = 18;
    localparam int BIP_SER_W   = 16;
    localparam int BIP_RATE_W  = 6;
    localparam int BIP_CNT_W   = 9;
    localparam int BIP_BIT_W   = 4;
    // data pins used as serial inputs in dual serial mode
    localparam int BIP_SER_I_PIN = 0;
    localparam int BIP_SER_Q_PIN = 1;
    // =====================================================
    // rate reset value, zero word, sign masks, last serial bit
    localparam logic [5:0] BIP_RATE_RST = 6'h01;
    localparam logic [17:0] BIP_ZERO18 = 18'h00000;
    localparam logic [17:0] BIP_SIGN18 = 18'h20000;
    localparam logic [15:0] BIP_SIGN16 = 16'h8000;
    localparam logic [3:0]  BIP_LAST_BIT = 4'hf;
    // fifo
    localparam int BIP_FIFO_DEPTH = 16;
    // inverse comb correction, coefficient shift (about -0.14/-0.28 dB)
    localparam int BIP_CMP_SH2 = 4;
    localparam int BIP_CMP_SHN = 3;
endpackage : bip_pkg
`default_nettype wire

// ### bip_top.sv
// baseband input port: port clock, gating, assembly, fifo, inverse comb
`default_nettype none

// =====================================================
// sample fifo
module bip_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire              do_wr = in_valid && in_ready;
    wire              do_rd = out_valid && out_ready;
    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    always_ff @(posedge clk)
    begin
        if (do_wr)
            mem[wr_ptr] <= in_data;
    end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (do_wr)
                wr_ptr <= wr_ptr + 1'b1;
            if (do_rd)
                rd_ptr <= rd_ptr + 1'b1;
            if (do_wr && !do_rd)
                count <= count + 1'b1;
            else if (do_rd && !do_wr)
                count <= count - 1'b1;
        end
    end
endmodule // bip_fifo

module bip_top
    import bip_pkg::*;
#(
    parameter int FIFO_DEPTH = BIP_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  resetn,
    // control settings
    input  wire logic [1:0]            operating_mode,
    input  wire logic                  dual_serial_mode,
    input  wire logic [BIP_RATE_W-1:0] comb_integrator_interp,
    input  wire logic                  port_clock_invert,
    input  wire logic                  port_clock_output_enable,
    input  wire logic                  port_clock_half_rate,
    input  wire logic                  transmit_gate_invert,
    input  wire logic                  hold_last_value,
    input  wire logic                  q_first_pairing,
    input  wire logic                  offset_binary,
    input  wire logic                  serial_lsb_first,
    input  wire logic                  inv_comb_bypass,
    // pins
    output logic                       port_data_clock,
    input  wire logic                  transmit_gate,
    input  wire logic [BIP_PAR_W-1:0]  port_data,
    // sample out to filter chain
    output logic                       sample_valid,
    input  wire logic                  sample_ready,
    output logic [BIP_PAR_W-1:0]       sample_i,
    output logic [BIP_PAR_W-1:0]       sample_q,
    output logic                       sample_real,
    output logic                       inv_comb_power,
    output logic                       overflow
);
    // =====================================================
    // pin synchronisers
    logic [1:0]           gate_s;
    logic [BIP_PAR_W-1:0] data_s1;
    logic [BIP_PAR_W-1:0] data_s2;
    wire gate_true = gate_s[1] ^ transmit_gate_invert;
    // =====================================================
    // mode decode
    wire is_serial = dual_serial_mode;
    wire is_interp = !is_serial && (operating_mode == BIP_MODE_INTERP);
    wire is_quad   = !is_serial && (operating_mode == BIP_MODE_QUAD);
    wire is_half   = is_quad && port_clock_half_rate;
    // =====================================================
    // port clock divider
    logic [BIP_CNT_W-1:0] div_cnt;
    logic                 pclk_int;
    wire [BIP_CNT_W-1:0] r_ext = BIP_CNT_W'(comb_integrator_interp);
    // half period in clk: 2R->R, 4R->2R, R->R/2 (min one)
    wire [BIP_CNT_W-1:0] half_per =
        is_serial ? ((r_ext >> 1) == '0 ? BIP_CNT_W'(1) : r_ext >> 1)
        : (is_interp || is_half) ? (r_ext << 1) : r_ext;
    wire toggle = (div_cnt >= half_per - 1'b1);
    wire rise   = toggle && !pclk_int;
    wire fall   = toggle && pclk_int;
    // active edge: invert picks the falling edge
    wire act_edge = port_clock_invert ? fall : rise;
    wire q_edge   = port_clock_invert ? rise : fall;
    wire cap_edge = is_half ? toggle : act_edge;
    // =====================================================
    // assembly state
    logic                 gate_d;
    logic                 phase;
    logic [BIP_BIT_W-1:0] bit_cnt;
    logic [BIP_SER_W-1:0] sh_i;
    logic [BIP_SER_W-1:0] sh_q;
    logic [BIP_PAR_W-1:0] word_first;
    logic [BIP_PAR_W-1:0] held;
    wire  gate_rise = gate_true && !gate_d;
    wire  take      = cap_edge && gate_true && (operating_mode != BIP_MODE_TONE);
    // offset binary to two's complement
    wire [BIP_PAR_W-1:0] par_word = offset_binary ?
        (data_s2 ^ BIP_SIGN18) : data_s2;
    wire si = data_s2[BIP_SER_I_PIN];
    wire sq = data_s2[BIP_SER_Q_PIN];
    wire [BIP_SER_W-1:0] nxt_i = serial_lsb_first ?
        {si, sh_i[BIP_SER_W-1:1]} : {sh_i[BIP_SER_W-2:0], si};
    wire [BIP_SER_W-1:0] nxt_q = serial_lsb_first ?
        {sq, sh_q[BIP_SER_W-1:1]} : {sh_q[BIP_SER_W-2:0], sq};
    wire [BIP_SER_W-1:0] fmt_i = offset_binary ? nxt_i ^ BIP_SIGN16 : nxt_i;
    wire [BIP_SER_W-1:0] fmt_q = offset_binary ? nxt_q ^ BIP_SIGN16 : nxt_q;
    // frame starts on gate rise, so counter restarts there
    wire [BIP_BIT_W-1:0] bit_now = gate_rise ? '0 : bit_cnt;
    // pair phase: 0 first word; half rate ties I/Q to edge
    wire second = is_half ? q_edge : (gate_rise ? 1'b0 : phase);
    wire ser_done  = is_serial && take && (bit_now == BIP_LAST_BIT);
    wire quad_done = is_quad && take && second;
    wire int_done  = is_interp && take;
    wire done      = ser_done || quad_done || int_done;
    // pairing order
    wire [BIP_PAR_W-1:0] pair_i = q_first_pairing ? par_word : word_first;
    wire [BIP_PAR_W-1:0] pair_q = q_first_pairing ? word_first : par_word;
    wire [2*BIP_PAR_W-1:0] raw =
        is_serial ? {fmt_i, 2'b00, fmt_q, 2'b00}
        : is_quad ? {pair_i, pair_q}
        : {par_word, BIP_ZERO18};
    // =====================================================
    // inverse comb: x - (x>>k)/4 cut, powered only when used
    wire cmp_on = !inv_comb_bypass && (comb_integrator_interp != 6'h01);
    localparam int SH2 = BIP_CMP_SH2;
    localparam int SHN = BIP_CMP_SHN;
    function automatic logic [BIP_PAR_W-1:0] bip_cmp(
        input logic [BIP_PAR_W-1:0] x, input logic two);
        logic signed [BIP_PAR_W-1:0] s;
        logic signed [BIP_PAR_W-1:0] d;
        s = $signed(x);
        d = two ? (s >>> SH2) : (s >>> SHN);
        // droop correction trades a small headroom loss for flatness
        return BIP_PAR_W'(s - (d >>> 1) + (d >>> 2));
    endfunction
    wire two_rate = (comb_integrator_interp == 6'h02);
    wire [2*BIP_PAR_W-1:0] comp = cmp_on ?
        {bip_cmp(raw[2*BIP_PAR_W-1:BIP_PAR_W], two_rate),
         bip_cmp(raw[BIP_PAR_W-1:0], two_rate)} : raw;
    // =====================================================
    // fifo between port and filter chain
    logic                   f_ready;
    logic                   f_valid;
    logic [2*BIP_PAR_W:0]   f_data;
    bip_fifo #(
        .WIDTH (2*BIP_PAR_W+1),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .in_valid  (done),
        .in_ready  (f_ready),
        .in_data   ({is_interp, comp}),
        .out_valid (f_valid),
        .out_ready (sample_ready || !sample_valid),
        .out_data  (f_data)
    );
    wire load_out = f_valid && (sample_ready || !sample_valid);
    // idle value while gate false: zeros or held sample
    wire [2*BIP_PAR_W-1:0] idle_val = hold_last_value ? {held, held} : '0;
    // =====================================================
    // registers
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            gate_s  <= '0;
            data_s1 <= '0;
            data_s2 <= '0;
            div_cnt <= '0;
            pclk_int <= 1'b0;
            port_data_clock <= 1'b0;
            gate_d  <= 1'b0;
            phase   <= 1'b0;
            bit_cnt <= '0;
            sh_i    <= '0;
            sh_q    <= '0;
            word_first <= '0;
            held    <= '0;
            sample_valid <= 1'b0;
            sample_i <= '0;
            sample_q <= '0;
            sample_real <= 1'b0;
            inv_comb_power <= 1'b0;
            overflow <= 1'b0;
        end
        else
        begin
            gate_s  <= {gate_s[0], transmit_gate};
            data_s1 <= port_data;
            data_s2 <= data_s1;
            div_cnt <= toggle ? '0 : div_cnt + 1'b1;
            pclk_int <= toggle ? !pclk_int : pclk_int;
            port_data_clock <= port_clock_output_enable
                ? (toggle ? !pclk_int : pclk_int) : 1'b0;
            gate_d <= gate_true;
            inv_comb_power <= cmp_on;
            overflow <= done && !f_ready;
            if (take)
            begin
                phase <= !second;
                bit_cnt <= bit_now + 1'b1;
                sh_i <= nxt_i;
                sh_q <= nxt_q;
                if (!second)
                    word_first <= par_word;
                held <= par_word;
            end
            else if (!gate_true)
            begin
                phase <= 1'b0;
                // a cut serial frame must not skew the next one
                bit_cnt <= '0;
                if (!hold_last_value)
                    held <= '0;
            end
            if (load_out)
            begin
                sample_valid <= 1'b1;
                sample_i <= f_data[2*BIP_PAR_W-1:BIP_PAR_W];
                sample_q <= f_data[BIP_PAR_W-1:0];
                sample_real <= f_data[2*BIP_PAR_W];
            end
            else if (sample_ready)
            begin
                sample_valid <= 1'b0;
                if (!gate_true)
                begin
                    sample_i <= idle_val[2*BIP_PAR_W-1:BIP_PAR_W];
                    sample_q <= hold_last_value ? sample_q : '0;
                end
            end
        end
    end
endmodule // bip_top
`default_nettype wire

// ### bip_src.sv
// baseband sample source model driving gate and data pins
`default_nettype none
module bip_src (
    // port clock from the device and setup
    input  wire logic        pclk,
    input  wire logic        inv_edge,
    input  wire logic        gate_inv,
    input  wire logic        ser,
    input  wire logic        lsb,
    // burst control
    input  wire logic        run,
    input  wire logic [4:0]  len,
    input  wire logic [17:0] base,
    // pins
    output logic             transmit_gate,
    output logic [17:0]      port_data,
    output logic             done
);
    logic [4:0] idx = 5'h00;
    logic       on  = 1'b0;
    logic [3:0] b;
    initial port_data = 18'h00000;
    assign b = lsb ? idx[3:0] : 4'hf - idx[3:0];
    assign transmit_gate = on ^ gate_inv;
    assign done = run && (idx == len);
    // =====================================================
    // change on the inactive edge so data is stable at capture
    always @(pclk)
    begin
        if (!run)
        begin
            idx <= 5'h00;
            on  <= 1'b0;
        end
        else if (pclk == inv_edge)
        begin
            on <= idx < len;
            // released bus toggles while run is high; once run drops it keeps its value
            port_data <= ~port_data;
            if (idx < len)
            begin
                idx <= idx + 5'h01;
                port_data <= ser ? {16'h0000, ~base[b], base[b]}
                                 : base + 18'(idx);
            end
        end
    end
endmodule // bip_src
`default_nettype wire

// ### bip_top_assertions.sv
// concurrent checks on the baseband input port
`default_nettype none
module bip_top_assertions
    import bip_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // settings
    input wire logic [1:0]  operating_mode,
    input wire logic        dual_serial_mode,
    input wire logic [5:0]  comb_integrator_interp,
    input wire logic        port_clock_output_enable,
    input wire logic        port_clock_half_rate,
    input wire logic        inv_comb_bypass,
    // outputs
    input wire logic        port_data_clock,
    input wire logic        sample_valid,
    input wire logic        sample_ready,
    input wire logic [17:0] sample_i,
    input wire logic [17:0] sample_q,
    input wire logic        sample_real,
    input wire logic        inv_comb_power
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // =====================================================
    // half period counter; settings only change under reset
    logic       pd_q;
    logic       seen;
    logic       tog;
    logic       on;
    logic [8:0] cnt;
    logic [8:0] half;
    logic [5:0] r;
    assign r = comb_integrator_interp;
    assign tog = pd_q != port_data_clock;
    assign on = port_clock_output_enable && operating_mode != BIP_MODE_TONE;
    assign half = dual_serial_mode ? {4'h0, r[5:1]}
        : (operating_mode == BIP_MODE_INTERP || port_clock_half_rate)
        ? {2'h0, r, 1'b0} : {3'h0, r};
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pd_q <= 1'b0;
            seen <= 1'b0;
            cnt  <= 9'h000;
        end
        else
        begin
            pd_q <= port_data_clock;
            seen <= seen | tog;
            cnt  <= tog ? 9'h000 : cnt + 9'h001;
        end
    end
    // =====================================================
    chk_clk_period: assert property (
        on && seen && tog |-> cnt == half - 9'h001)
        else $error("port clock half period wrong");
    chk_pin_off: assert property (
        (!port_clock_output_enable)[*2] |-> !port_data_clock)
        else $error("disabled port clock pin not low");
    chk_sample_hold: assert property (
        sample_valid && !sample_ready |=> sample_valid
        && $stable(sample_i) && $stable(sample_q))
        else $error("sample dropped before accept");
    chk_comb_off: assert property (
        (inv_comb_bypass || r == 6'h01)[*2] |-> !inv_comb_power)
        else $error("bypassed stage still powered");
    chk_comb_on: assert property (
        (!inv_comb_bypass && r != 6'h01
        && operating_mode == BIP_MODE_QUAD)[*2] |-> inv_comb_power)
        else $error("active stage not powered");
    chk_real_flag: assert property (
        sample_valid |-> sample_real
        == (operating_mode == BIP_MODE_INTERP && !dual_serial_mode))
        else $error("real sample flag wrong");
    chk_tone_idle: assert property (
        operating_mode == BIP_MODE_TONE && !dual_serial_mode
        |-> !sample_valid)
        else $error("sample in tone mode");
    chk_serial_lsbs: assert property (
        sample_valid && dual_serial_mode
        |-> sample_i[1:0] == 2'h0 && sample_q[1:0] == 2'h0)
        else $error("serial word low bits set");
    chk_reset_quiet: assert property (
        $rose(resetn) |-> !sample_valid && !port_data_clock)
        else $error("outputs active after reset");
    cover property (sample_valid && sample_ready);
    cover property (sample_valid && dual_serial_mode);
    cover property (port_clock_half_rate && tog);
endmodule // bip_top_assertions
bind bip_top bip_top_assertions u_bip_top_assertions (
    .clk(clk), .resetn(resetn), .operating_mode(operating_mode),
    .dual_serial_mode(dual_serial_mode),
    .comb_integrator_interp(comb_integrator_interp),
    .port_clock_output_enable(port_clock_output_enable),
    .port_clock_half_rate(port_clock_half_rate),
    .inv_comb_bypass(inv_comb_bypass), .port_data_clock(port_data_clock),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample_i(sample_i), .sample_q(sample_q), .sample_real(sample_real),
    .inv_comb_power(inv_comb_power));
`default_nettype wire

// ### bip_top_tb.sv
// testbench for the baseband input port
`default_nettype none
module bip_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [1:0]  mode = 2'h0;
    logic [5:0]  rr = 6'h04;
    logic        ser = 1'b0, pci = 1'b0, en = 1'b1, hr = 1'b0, tgi = 1'b0;
    logic        qf = 1'b0, ob = 1'b0, lsbf = 1'b0, byp = 1'b1, rdy = 1'b1;
    logic        run = 1'b0, ovf_seen = 1'b0, hlv = 1'b0;
    logic [4:0]  len = 5'h00;
    logic [17:0] base = 18'h00000;
    logic        pdc, tg, done, sv, sr, icp, ovf;
    logic [17:0] pd, si, sq;
    logic [36:0] got[$];
    int          mismatches = 0;
    int          n_compared = 0;
    int          cycles = 0;
    always #5 clk = ~clk;
    bip_top u_bip_top (.clk(clk), .resetn(resetn), .operating_mode(mode),
        .dual_serial_mode(ser), .comb_integrator_interp(rr),
        .port_clock_invert(pci), .port_clock_output_enable(en),
        .port_clock_half_rate(hr), .transmit_gate_invert(tgi),
        .hold_last_value(hlv), .q_first_pairing(qf), .offset_binary(ob),
        .serial_lsb_first(lsbf), .inv_comb_bypass(byp),
        .port_data_clock(pdc), .transmit_gate(tg), .port_data(pd),
        .sample_valid(sv), .sample_ready(rdy), .sample_i(si),
        .sample_q(sq), .sample_real(sr), .inv_comb_power(icp),
        .overflow(ovf));
    bip_src u_bip_src (.pclk(pdc), .inv_edge(pci), .gate_inv(tgi),
        .ser(ser), .lsb(lsbf), .run(run), .len(len), .base(base),
        .transmit_gate(tg), .port_data(pd), .done(done));
    // =====================================================
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (sv === 1'b1 && rdy)
            got.push_back({sr, si, sq});
        if (ovf === 1'b1)
            ovf_seen <= 1'b1;
        if (cycles == 30000)
        begin
            mismatches++;
            print_verdict();
        end
    end
    task automatic print_verdict;
        if (mismatches == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [36:0] g, input logic [36:0] e);
        n_compared++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic hold_rst;
        @(negedge clk);
        resetn = 1'b0;
        {run, ser, pci, hr, tgi, qf, ob, lsbf, hlv} = 9'h000;
        {en, byp, rdy, mode, rr} = {3'h7, 2'h0, 6'h04};
        ovf_seen = 1'b0;
        got.delete();
    endtask
    task automatic rel;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        // let the port clock move so the source sees run low
        repeat (40) @(negedge clk);
    endtask
    // one burst; bounded wait for the source, then drain time
    task automatic go(input logic [4:0] n, input logic [17:0] b);
        int k;
        rel();
        {len, base, run} = {n, b, 1'b1};
        for (k = 0; k < 2000 && done !== 1'b1; k++)
            @(negedge clk);
        repeat (40) @(negedge clk);
        run = 1'b0;
    endtask
    // =====================================================
    task automatic t_quad;
        hold_rst();
        go(5'd5, 18'h00100);
        cmp(37'(got.size()), 37'd2);
        cmp(got[0], {1'b0, 18'h00100, 18'h00101});
        cmp(got[1], {1'b0, 18'h00102, 18'h00103});
        hold_rst();
        qf = 1'b1;
        go(5'd4, 18'h00200);
        cmp(got[1], {1'b0, 18'h00203, 18'h00202});
    endtask
    // gate inverted, falling capture, offset binary input
    task automatic t_gate_inv;
        hold_rst();
        {tgi, pci, ob} = 3'h7;
        go(5'd2, 18'h00300);
        cmp(got[0], {1'b0, 18'h20300, 18'h20301});
        cmp(37'(si), 37'h0);
        hold_rst();
        {tgi, pci, ob, hlv} = 4'hf;
        go(5'd2, 18'h00300);
        cmp(37'(si), 37'h20301);
    endtask
    // real samples; stalled chain fills the fifo until it refuses
    task automatic t_interp;
        hold_rst();
        {mode, rdy} = {2'h1, 1'b0};
        go(5'd19, 18'h00400);
        cmp(37'(ovf_seen), 37'h1);
        rdy = 1'b1;
        repeat (40) @(negedge clk);
        cmp(37'(got[1][36:18]), {18'h0, 1'b1, 18'h00401});
    endtask
    task automatic t_serial;
        int k;
        for (k = 0; k < 2; k++)
        begin
            hold_rst();
            {ser, rr, lsbf} = {1'b1, 6'h08, k[0]};
            go(5'd16, 18'h0a5c3);
            cmp(got[0], {1'b0, 16'ha5c3, 2'h0, 16'h5a3c, 2'h0});
        end
    endtask
    task automatic t_tone;
        hold_rst();
        mode = 2'h2;
        go(5'd4, 18'h00600);
        cmp(37'(got.size()), 37'd0);
    endtask
    // pin off, half rate clock count, comb stage power
    task automatic t_clocks;
        int n;
        int k;
        logic prev;
        hold_rst();
        en = 1'b0;
        rel();
        n = 0;
        for (k = 0; k < 100; k++)
        begin
            @(negedge clk);
            n += (pdc !== 1'b0);
        end
        cmp(37'(n), 37'd0);
        cmp(37'(icp), 37'h0);
        hold_rst();
        {hr, byp} = 2'h2;
        rel();
        repeat (100) @(negedge clk);
        n = 0;
        prev = pdc;
        for (k = 0; k < 160; k++)
        begin
            @(negedge clk);
            n += (pdc === 1'b1 && prev === 1'b0);
            prev = pdc;
        end
        cmp(37'(n), 37'd10);
        cmp(37'(icp), 37'h1);
    endtask
    initial
    begin
        repeat (20) @(negedge clk);
        t_quad();
        t_gate_inv();
        t_interp();
        t_serial();
        t_tone();
        t_clocks();
        print_verdict();
    end
endmodule // bip_top_tb
`default_nettype wire
